/* File: inc/qro_defines.vh */
`ifndef QRO_DEFINES_VH
`define QRO_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets on the Avalon-MM slave
`define QRO_OFS_CTRL        4'h0
`define QRO_OFS_STATUS      4'h4
`define QRO_OFS_IRQ_STAT    4'h8
`define QRO_OFS_IRQ_MASK    4'hc

////////////////////////////////////////////////////////////////////////////////
// Control register fields
`define QRO_CTRL_CFG_DONE   0
`define QRO_CTRL_BUS_EN     1
`define QRO_CTRL_RST        2'h0

////////////////////////////////////////////////////////////////////////////////
// Status register fields
`define QRO_STAT_LEADER     0
`define QRO_STAT_SELECTED   1
`define QRO_STAT_CFG_DONE   2
`define QRO_STAT_IN_RESET   3
`define QRO_STAT_FLAG       4
`define QRO_STAT_QUEUE_LSB  8
`define QRO_STAT_DEV_LSB    16

////////////////////////////////////////////////////////////////////////////////
// Interrupt event bits (status and mask share this layout)
`define QRO_IRQ_W           3
`define QRO_IRQ_RST_DONE    0
`define QRO_IRQ_ALMOST_MT   1
`define QRO_IRQ_SELECTED    2
`define QRO_IRQ_RST         3'h0

////////////////////////////////////////////////////////////////////////////////
// Read port geometry
`define QRO_ADDR_W          8
`define QRO_DEV_W           3
`define QRO_QUEUE_W         5
`define QRO_QUEUES          32
`define QRO_WORD_W          8
`define QRO_DATA_W          36

`endif

/* File: logic/qro_sync2.v */
`timescale 1ns/1ps

// Two-stage synchroniser for levels arriving from outside the clock domain
module qro_sync2 #(
    parameter             WIDTH = 1,     // Number of bits
    parameter [WIDTH-1:0] INIT  = {WIDTH{1'b0}} // Reset value
)(
    input  wire             sys_clk_i,   // System clock
    input  wire             sys_rst_i,   // Async reset, active high
    input  wire [WIDTH-1:0] async_i,     // Unsynchronised level
    output reg  [WIDTH-1:0] sync_o       // Synchronised level
);

    reg [WIDTH-1:0] meta_q;              // First stage, read only by sync_o

    ////////////////////////////////////////////////////////////////////////////
    // Two flops in series
    always @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            meta_q <= INIT;
            sync_o <= INIT;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule // qro_sync2

/* File: logic/qro_irq_regs.v */
`timescale 1ns/1ps
`include "qro_defines.vh"

// Sticky event status with write-one-to-clear, mask and level interrupt
module qro_irq_regs (
    input  wire                  sys_clk_i,   // System clock
    input  wire                  sys_rst_i,   // Async reset, active high
    input  wire [`QRO_IRQ_W-1:0] event_i,     // One-cycle event pulses
    input  wire                  clr_we_i,    // Write strobe to status
    input  wire                  mask_we_i,   // Write strobe to mask
    input  wire [`QRO_IRQ_W-1:0] wdata_i,     // Write data, lane 0
    output reg  [`QRO_IRQ_W-1:0] status_o,    // Sticky status
    output reg  [`QRO_IRQ_W-1:0] mask_o,      // Interrupt mask
    output reg                   irq_o        // Level interrupt
);

    wire [`QRO_IRQ_W-1:0] status_d;           // Next status value

    // Set wins over a clear in the same cycle
    assign status_d = event_i | (status_o & ~({`QRO_IRQ_W{clr_we_i}} & wdata_i));

    ////////////////////////////////////////////////////////////////////////////
    // Status, mask and interrupt flops
    always @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            status_o <= `QRO_IRQ_RST;
            mask_o   <= `QRO_IRQ_RST;
            irq_o    <= 1'b0;
        end
        else
        begin
            status_o <= status_d;
            if (mask_we_i)
            begin
                mask_o <= wdata_i;
            end
            // Uses next values so the line tracks status with no extra lag
            irq_o <= |(status_d & (mask_we_i ? wdata_i : mask_o));
        end
    end

endmodule // qro_irq_regs

/* File: logic/qro_read_ctrl.v */
`timescale 1ns/1ps
`include "qro_defines.vh"

// How it works
// - Chain-role pin sampled during chip reset
// - Leader drives outputs; followers stay high impedance until selected
// - Leader: output enable low drives data asynchronously
// - Leader: output enable high floats data
// - Follower floats data until selected on read
// - Discrete flag follows queue selected for reading
// - Flag low while selected queue almost empty
// - Flag changes only on read clock edges
// - Flag also mirrored on flag bus line
// - Address: upper bits device, lower bits queue
module qro_read_ctrl (
    input  wire                     sys_clk_i,               // Read clock
    input  wire                     sys_rst_i,               // Async reset, active high
    // Avalon-MM slave
    input  wire [3:0]               avs_address_i,           // Byte address
    input  wire                     avs_read_i,              // Read request
    input  wire                     avs_write_i,             // Write request
    input  wire [31:0]              avs_writedata_i,         // Write data
    input  wire [3:0]               avs_byteenable_i,        // Byte enables
    output reg  [31:0]              avs_readdata_o,          // Read data
    output reg                      avs_waitrequest_o,       // Wait request
    output wire                     irq_o,                   // Level interrupt
    // Chain and reset pins
    input  wire                     chip_reset_n_i,          // Chip reset, active low
    input  wire                     chain_leader_select_i,   // Chain role pin
    input  wire [`QRO_DEV_W-1:0]    device_number_pins_i,    // Device number
    input  wire                     output_enable_n_i,       // Output enable, active low
    // Read port, synchronous to the read clock
    input  wire [`QRO_ADDR_W-1:0]   read_queue_address_i,    // Queue address
    input  wire                     read_addr_strobe_i,      // Address strobe
    input  wire [`QRO_QUEUES-1:0]   queue_almost_empty_i,    // Per-queue almost empty
    input  wire [`QRO_DATA_W-1:0]   core_read_data_i,        // Data from the queue memory
    // Pin outputs with their enables
    output reg  [`QRO_DATA_W-1:0]   read_data_o,             // Read data pins
    output wire                     read_data_oe_o,          // Read data drive enable
    output reg                      almost_empty_flag_n_o,   // Discrete flag, low = almost empty
    output reg                      almost_empty_flag_n_oe_o,// Discrete flag drive enable
    output reg  [`QRO_WORD_W-1:0]   almost_empty_flag_bus_o, // Flag bus, low = almost empty
    output reg                      almost_empty_flag_bus_oe_o // Flag bus drive enable
);

    ////////////////////////////////////////////////////////////////////////////
    // Device match on the upper address bits
    function dev_match;
        input [`QRO_ADDR_W-1:0] addr;
        input [`QRO_DEV_W-1:0]  dev;
        begin
            dev_match = (addr[`QRO_ADDR_W-1:`QRO_QUEUE_W] == dev);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    wire                   rst_n_s;          // Synchronised chip reset
    wire                   leader_s;         // Synchronised chain role pin
    wire [`QRO_DEV_W-1:0]  dev_s;            // Synchronised device number
    reg                    rst_n_q;          // Chip reset, previous cycle
    reg                    leader_q;         // Captured chain role
    reg  [`QRO_DEV_W-1:0]  dev_q;            // Captured device number
    reg                    selected_q;       // This device selected for reading
    reg  [`QRO_QUEUE_W-1:0] queue_q;         // Queue selected for reading
    reg                    cfg_done_q;       // Software finished configuring
    reg                    bus_en_q;         // Flag bus mirrors queue status
    reg                    permit_q;         // Data drive allowed by role or selection
    reg                    flag_prev_q;      // Flag value last cycle
    wire                   in_reset;         // Chip reset held low
    wire                   strobe_hit;       // Strobe addresses this device
    wire                   active;           // Queue operation allowed
    wire                   flag_d;           // Next discrete flag
    wire [`QRO_WORD_W-1:0] bus_d;            // Next flag bus word
    wire                   req;              // Bus request present
    wire                   xfer;             // Bus transfer completes now
    wire                   wr_xfer;          // Completing write
    reg  [31:0]            rdata_d;          // Read mux
    wire [`QRO_IRQ_W-1:0]  irq_stat;         // Sticky event status
    wire [`QRO_IRQ_W-1:0]  irq_mask;         // Event mask
    wire [`QRO_IRQ_W-1:0]  irq_evt;          // Event pulses

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    qro_sync2 #(
        .WIDTH (1),
        .INIT  (1'b0)
    ) u_sync_rst (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (chip_reset_n_i),
        .sync_o    (rst_n_s)
    );

    qro_sync2 #(
        .WIDTH (1 + `QRO_DEV_W),
        .INIT  ({(1 + `QRO_DEV_W){1'b0}})
    ) u_sync_role (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   ({chain_leader_select_i, device_number_pins_i}),
        .sync_o    ({leader_s, dev_s})
    );

    assign in_reset   = ~rst_n_s;
    assign strobe_hit = dev_match(read_queue_address_i, dev_q);
    assign active     = rst_n_s & cfg_done_q;

    ////////////////////////////////////////////////////////////////////////////
    // Role and device number capture around chip reset
    always @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rst_n_q  <= 1'b0;
            leader_q <= 1'b0;
            dev_q    <= {`QRO_DEV_W{1'b0}};
        end
        else
        begin
            rst_n_q <= rst_n_s;
            // Track the pins while reset is low, freeze from release on
            if (in_reset)
            begin
                leader_q <= leader_s;
                dev_q    <= dev_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port queue selection
    always @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            selected_q <= 1'b0;
            queue_q    <= {`QRO_QUEUE_W{1'b0}};
        end
        else if (in_reset)
        begin
            // Chip reset drops any selection
            selected_q <= 1'b0;
            queue_q    <= {`QRO_QUEUE_W{1'b0}};
        end
        else if (read_addr_strobe_i)
        begin
            selected_q <= strobe_hit;
            // Queue only changes when this device is addressed
            if (strobe_hit)
            begin
                queue_q <= read_queue_address_i[`QRO_QUEUE_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output drive permission from role and selection
    always @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            permit_q                   <= 1'b0;
            almost_empty_flag_n_oe_o   <= 1'b0;
            almost_empty_flag_bus_oe_o <= 1'b0;
        end
        else
        begin
            // Leader drives; a follower waits until it is selected
            permit_q                   <= leader_q | selected_q;
            almost_empty_flag_n_oe_o   <= leader_q | selected_q;
            almost_empty_flag_bus_oe_o <= (leader_q | selected_q) & bus_en_q;
        end
    end

    // Output enable acts on the data drive with no clock in its path
    assign read_data_oe_o = permit_q & ~output_enable_n_i;

    ////////////////////////////////////////////////////////////////////////////
    // Flags, synchronous to the read clock
    assign flag_d = active ? ~queue_almost_empty_i[queue_q] : 1'b1;
    assign bus_d  = active ? ~queue_almost_empty_i[{queue_q[`QRO_QUEUE_W-1:3], 3'h0} +: `QRO_WORD_W]
                           : {`QRO_WORD_W{1'b1}};

    always @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            almost_empty_flag_n_o   <= 1'b1;
            almost_empty_flag_bus_o <= {`QRO_WORD_W{1'b1}};
            flag_prev_q             <= 1'b1;
            read_data_o             <= {`QRO_DATA_W{1'b0}};
        end
        else
        begin
            almost_empty_flag_n_o   <= flag_d;
            almost_empty_flag_bus_o <= bus_d;
            flag_prev_q             <= almost_empty_flag_n_o;
            // Data only follows the core while this device may drive
            if (active & permit_q)
            begin
                read_data_o <= core_read_data_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Avalon-MM handshake: one wait cycle, then the transfer
    assign req     = avs_read_i | avs_write_i;
    assign xfer    = req & ~avs_waitrequest_o;
    assign wr_xfer = avs_write_i & ~avs_waitrequest_o;

    always @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            avs_waitrequest_o <= 1'b1;
        end
        else
        begin
            // Low for exactly one cycle per request
            avs_waitrequest_o <= ~(req & avs_waitrequest_o);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped offsets read as zero
    always @*
    begin
        rdata_d = 32'h0000_0000;
        case (avs_address_i)
            `QRO_OFS_CTRL:
            begin
                rdata_d[`QRO_CTRL_CFG_DONE] = cfg_done_q;
                rdata_d[`QRO_CTRL_BUS_EN]   = bus_en_q;
            end
            `QRO_OFS_STATUS:
            begin
                rdata_d[`QRO_STAT_LEADER]   = leader_q;
                rdata_d[`QRO_STAT_SELECTED] = selected_q;
                rdata_d[`QRO_STAT_CFG_DONE] = cfg_done_q;
                rdata_d[`QRO_STAT_IN_RESET] = in_reset;
                rdata_d[`QRO_STAT_FLAG]     = almost_empty_flag_n_o;
                rdata_d[`QRO_STAT_QUEUE_LSB +: `QRO_QUEUE_W] = queue_q;
                rdata_d[`QRO_STAT_DEV_LSB +: `QRO_DEV_W]     = dev_q;
            end
            `QRO_OFS_IRQ_STAT:
            begin
                rdata_d[`QRO_IRQ_W-1:0] = irq_stat;
            end
            `QRO_OFS_IRQ_MASK:
            begin
                rdata_d[`QRO_IRQ_W-1:0] = irq_mask;
            end
            default:
            begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data capture, ready at the completing edge
    always @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            avs_readdata_o <= 32'h0000_0000;
        end
        else if (avs_read_i & avs_waitrequest_o)
        begin
            avs_readdata_o <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register; chip reset forces reconfiguration
    always @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cfg_done_q <= 1'b0;
            bus_en_q   <= 1'b0;
        end
        else if (in_reset)
        begin
            // Configuration is lost on every chip reset
            cfg_done_q <= 1'b0;
            bus_en_q   <= 1'b0;
        end
        else if (wr_xfer & (avs_address_i == `QRO_OFS_CTRL) & avs_byteenable_i[0])
        begin
            cfg_done_q <= avs_writedata_i[`QRO_CTRL_CFG_DONE];
            bus_en_q   <= avs_writedata_i[`QRO_CTRL_BUS_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt events
    assign irq_evt[`QRO_IRQ_RST_DONE]  = rst_n_s & ~rst_n_q;
    assign irq_evt[`QRO_IRQ_ALMOST_MT] = flag_prev_q & ~almost_empty_flag_n_o;
    assign irq_evt[`QRO_IRQ_SELECTED]  = read_addr_strobe_i & strobe_hit & ~selected_q & rst_n_s;

    qro_irq_regs u_irq (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .event_i   (irq_evt),
        .clr_we_i  (wr_xfer & (avs_address_i == `QRO_OFS_IRQ_STAT) & avs_byteenable_i[0]),
        .mask_we_i (wr_xfer & (avs_address_i == `QRO_OFS_IRQ_MASK) & avs_byteenable_i[0]),
        .wdata_i   (avs_writedata_i[`QRO_IRQ_W-1:0]),
        .status_o  (irq_stat),
        .mask_o    (irq_mask),
        .irq_o     (irq_o)
    );

endmodule // qro_read_ctrl

/* File: verif/qro_read_sva.sv */
`timescale 1ns/1ps
`include "qro_defines.vh"

// Port-level checks on the register bus and read-side pins
module qro_read_sva (
    input logic                   sys_clk_i,
    input logic                   sys_rst_i,
    input logic [3:0]             avs_address_i,
    input logic                   avs_read_i,
    input logic                   avs_write_i,
    input logic [31:0]            avs_readdata_o,
    input logic                   avs_waitrequest_o,
    input logic                   irq_o,
    input logic                   chip_reset_n_i,
    input logic                   output_enable_n_i,
    input logic [`QRO_QUEUES-1:0] queue_almost_empty_i,
    input logic                   read_data_oe_o,
    input logic                   almost_empty_flag_n_o,
    input logic                   almost_empty_flag_n_oe_o,
    input logic [`QRO_WORD_W-1:0] almost_empty_flag_bus_o,
    input logic                   almost_empty_flag_bus_oe_o
);
    ////////////////////////////////////////////////////////////////////////////
    // One clock domain for everything
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    ////////////////////////////////////////////////////////////////////////////
    // Quiet pins while the block is held in reset
    reset_idle_a: assert property (disable iff (1'b0) sys_rst_i |-> avs_waitrequest_o && !irq_o
        && !read_data_oe_o && almost_empty_flag_n_o && almost_empty_flag_bus_o == 8'hff)
        else $error("outputs not idle in reset");
    // One wait cycle per request, never more
    answer_next_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("request not answered next cycle");
    wait_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    no_answer_a: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
        else $error("answer without request");
    // Holes in the map read as zero
    unmapped_zero_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i[1:0] != 2'h0
        |-> avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");
    // Data drive only while the enable pin is low
    oe_pin_a: assert property (read_data_oe_o |-> !output_enable_n_i)
        else $error("data driven with enable high");
    // A low flag needs an almost-empty queue behind it
    flag_cause_a: assert property (!almost_empty_flag_n_o |-> $past(queue_almost_empty_i) != 32'h0)
        else $error("flag low without cause");
    // Held chip reset forces flags inactive
    chip_quiet_a: assert property (!chip_reset_n_i [*5] |=> almost_empty_flag_n_o
        && !almost_empty_flag_bus_oe_o)
        else $error("flags active in chip reset");
    // Discrete flag mirrored on the bus word
    bus_mirror_a: assert property (almost_empty_flag_bus_oe_o && almost_empty_flag_n_oe_o
        && !almost_empty_flag_n_o |-> almost_empty_flag_bus_o != 8'hff)
        else $error("flag missing from bus");

    ////////////////////////////////////////////////////////////////////////////
    // Main scenarios reached
    irq_seen_c: cover property (irq_o);
    oe_rise_c: cover property ($rose(read_data_oe_o));
    flag_low_c: cover property (!almost_empty_flag_n_o);
endmodule // qro_read_sva

/* File: verif/qro_reader_model.sv */
`timescale 1ns/1ps

// Reading logic on the far side: issues queue selections
module qro_reader_model (
    input  logic        sys_clk_i,            // Read clock
    input  logic        sel_req_i,            // Selection wanted
    input  logic [7:0]  sel_addr_i,           // Device and queue
    output logic [7:0]  read_queue_address_o, // Address pins
    output logic        read_addr_strobe_o,   // Address strobe
    output logic [35:0] core_read_data_o      // Memory data pattern
);
    initial {read_queue_address_o, read_addr_strobe_o, core_read_data_o} = 45'h0;

    // One-cycle strobe; address scrambled outside the strobe
    always @(posedge sys_clk_i)
    begin
        read_addr_strobe_o <= sel_req_i;
        if (sel_req_i)
            read_queue_address_o <= sel_addr_i;
        else
            read_queue_address_o <= ~read_queue_address_o;
        core_read_data_o <= core_read_data_o + 36'h1;
    end
endmodule // qro_reader_model

/* File: verif/queue_read_side_output_control_test.sv */
`timescale 1ns/1ps
`include "qro_defines.vh"

// Bench for the read-side output control
module queue_read_side_output_control_test;
    logic        sys_clk_i = 0, sys_rst_i = 0;    // Reset raised at time zero
    logic [3:0]  avs_address_i = 4'h0;
    logic        avs_read_i = 0, avs_write_i = 0;
    logic [31:0] avs_writedata_i = 32'h0, rd;     // Bus write and read data
    logic [3:0]  avs_byteenable_i = 4'hf;         // All lanes
    logic        chip_reset_n_i = 1, chain_leader_select_i = 1, output_enable_n_i = 1;
    logic [2:0]  device_number_pins_i = 3'h0;     // Device number
    logic [31:0] queue_almost_empty_i = 32'h0;    // Per-queue status
    logic        sel_req = 0;                     // Model request
    logic [7:0]  sel_addr = 8'h00;                // Model address
    wire  [7:0]  read_queue_address_i, almost_empty_flag_bus_o;
    wire         read_addr_strobe_i, irq_o, avs_waitrequest_o, read_data_oe_o;
    wire  [35:0] core_read_data_i, read_data_o;
    wire  [31:0] avs_readdata_o;
    wire         almost_empty_flag_n_o, almost_empty_flag_n_oe_o, almost_empty_flag_bus_oe_o;
    int          fail_count = 0, checks = 0, base;
    // Rows: address, almost-empty vector, expected flag
    logic [40:0] rows [0:4] = '{{8'h03, 32'h0000_0008, 1'b0}, {8'h03, 32'hffff_fff7, 1'b1},
        {8'h1f, 32'h8000_0000, 1'b0}, {8'h10, 32'h0001_0000, 1'b0}, {8'h08, 32'h0000_0000, 1'b1}};

    always #10 sys_clk_i = ~sys_clk_i;

    qro_read_ctrl dut (.sys_clk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .irq_o, .chip_reset_n_i, .chain_leader_select_i,
        .device_number_pins_i, .output_enable_n_i, .read_queue_address_i, .read_addr_strobe_i,
        .queue_almost_empty_i, .core_read_data_i, .read_data_o, .read_data_oe_o, .almost_empty_flag_n_o,
        .almost_empty_flag_n_oe_o, .almost_empty_flag_bus_o, .almost_empty_flag_bus_oe_o);
    qro_reader_model far (.sys_clk_i, .sel_req_i(sel_req), .sel_addr_i(sel_addr),
        .read_queue_address_o(read_queue_address_i), .read_addr_strobe_o(read_addr_strobe_i),
        .core_read_data_o(core_read_data_i));

    ////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One Avalon transfer, held until waitrequest is seen low
    task bus_op(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        avs_address_i <= a;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_writedata_i <= d;
        do
        begin
            @(posedge sys_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        rd = avs_readdata_o;
        if (n >= 50) check("waitrequest", avs_waitrequest_o, 32'h0);
        avs_read_i <= 0;
        avs_write_i <= 0;
    endtask
    // High-low-high chip reset with role and number set
    task chip_reset(input logic role, input logic [2:0] dev);
        chain_leader_select_i <= role;
        device_number_pins_i <= dev;
        chip_reset_n_i <= 0;
        repeat (6) @(posedge sys_clk_i);
        chip_reset_n_i <= 1;
        repeat (4) @(posedge sys_clk_i);
    endtask
    // Selection through the far-side model, then settle
    task select(input logic [7:0] a);
        sel_addr <= a;
        sel_req <= 1;
        @(posedge sys_clk_i);
        sel_req <= 0;
        repeat (6) @(posedge sys_clk_i);
    endtask
    // Verdict and end of run
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog against a hang
    initial
    begin
        #400000;
        fail_count++;
        tally_and_finish;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        sys_rst_i <= 1;
        repeat (16) @(posedge sys_clk_i);
        check("idle wait", avs_waitrequest_o, 1);
        check("idle flag", almost_empty_flag_n_o, 1);
        check("idle oe", read_data_oe_o, 0);
        sys_rst_i <= 0;
        $display("test reset done");
        // Leader, single device; registers and interrupt
        chip_reset(1, 3'h0);
        bus_op(0, `QRO_OFS_STATUS, 0);
        check("leader bit", rd[0], 1);
        check("cfg bit", rd[3:2], 0);
        bus_op(0, `QRO_OFS_IRQ_STAT, 0);
        check("reset event", rd[0], 1);
        check("irq masked", irq_o, 0);
        bus_op(1, `QRO_OFS_IRQ_MASK, 1);
        repeat (2) @(posedge sys_clk_i);
        check("irq raised", irq_o, 1);
        bus_op(1, `QRO_OFS_IRQ_STAT, 1);
        repeat (2) @(posedge sys_clk_i);
        check("irq cleared", irq_o, 0);
        bus_op(0, 4'h2, 0);
        check("unmapped", rd, 0);
        bus_op(1, `QRO_OFS_CTRL, 3);
        $display("test registers done");
        // Enable pin acts within the cycle
        output_enable_n_i <= 0;
        #3 check("oe low", read_data_oe_o, 1);
        @(posedge sys_clk_i);
        output_enable_n_i <= 1;
        #3 check("oe high", read_data_oe_o, 0);
        @(posedge sys_clk_i);
        $display("test enable done");
        // Queue selection table
        for (int i = 0; i < 5; i++)
        begin
            queue_almost_empty_i <= rows[i][32:1];
            select(rows[i][40:33]);
            base = {rows[i][37:36], 3'b000};
            check("flag", almost_empty_flag_n_o, rows[i][0]);
            check("flag oe", almost_empty_flag_n_oe_o, 1);
            check("bus", almost_empty_flag_bus_o, 8'(~rows[i][1+base+:8]));
            check("data", read_data_o[31:0], core_read_data_i[31:0] - 1);
        end
        $display("test table done");
        // Follower: floats until selected, role frozen
        chip_reset(0, 3'h2);
        chain_leader_select_i <= 1;
        output_enable_n_i <= 0;
        queue_almost_empty_i <= 32'h0000_0020;
        repeat (3) @(posedge sys_clk_i);
        bus_op(0, `QRO_OFS_STATUS, 0);
        check("role held", rd[0], 0);
        check("device no", rd[18:16], 2);
        bus_op(1, `QRO_OFS_CTRL, 3);
        repeat (2) @(posedge sys_clk_i);
        check("follower oe", read_data_oe_o, 0);
        check("follower flag oe", almost_empty_flag_n_oe_o, 0);
        select(8'h45);
        check("selected oe", read_data_oe_o, 1);
        check("selected flag", almost_empty_flag_n_o, 0);
        select(8'h05);
        check("other device", read_data_oe_o, 0);
        bus_op(0, `QRO_OFS_IRQ_STAT, 0);
        check("events", rd, 7);
        $display("test follower done");
        tally_and_finish;
    end
endmodule // queue_read_side_output_control_test

bind qro_read_ctrl qro_read_sva chk (.sys_clk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_readdata_o, .avs_waitrequest_o, .irq_o, .chip_reset_n_i, .output_enable_n_i, .queue_almost_empty_i,
    .read_data_oe_o, .almost_empty_flag_n_o, .almost_empty_flag_n_oe_o, .almost_empty_flag_bus_o,
    .almost_empty_flag_bus_oe_o);
